// ### logic/dpss_pkg.sv
// constants, field layout and carrier types of the dual pll serial synthesiser
// assumes one 200 MHz clock; every pin input is already synchronous to it
//
// Notes on behaviour
// - each serial clock rising edge shifts one data bit into the 23-bit register.
// - while latch strobe high, shift word goes to tx latch if select high, else rx.
// - each section has a 7-bit binary swallow counter, values 0 to 127.
// - each prescaler divides by 64 or 65, steered by the swallow counter.
// - locked vco runs at (64*N + A) times crystal over reference ratio; A below N.
// - counter fields are plain binary, lowest-numbered bit least significant.
// - shared reference counter divides crystal by 512 when ratio bit high, else 1024.
// - divider monitor shows tx divider when monitor select high, rx divider when low.
// - a separate monitor output carries the reference counter output.
// - polarity high drives high when reference leads, low when lags, else released.
// - lock flag drops low as soon as phase error reaches the lock window.
// - lock flag rises only after three or more consecutive in-window comparisons.
// - phase detector resolves differences over minus to plus two pi.
// - locked detector still emits short correction pulses each comparison, no dead band.
// - tx switch on only with strobe and select high, rx with strobe and select low.
package dpss_pkg;
    localparam int SR_BITS = 23;
    localparam int N_W = 11;
    localparam int A_W = 7;
    // serial word positions, bit 0 is the last one shifted
    localparam int POS_SEL = 0;
    localparam int POS_REF = 1;
    localparam int POS_MON = 2;
    localparam int POS_FILL = 3;
    localparam int POS_POL = 4;
    localparam int POS_A_LSB = 5;
    localparam int POS_N_LSB = 12;
    // divide ratios
    localparam int REF_DIV_HI = 512;
    localparam int REF_DIV_LO = 1024;
    localparam int PRESCALE_MOD = 64;
    localparam int N_MIN = 16;
    // lock window timing
    localparam int CLK_MHZ = 200;
    localparam int LOCK_WINDOW_NS = 625;
    localparam int LOCK_WINDOW_CYC = (LOCK_WINDOW_NS * CLK_MHZ + 999) / 1000;
    localparam int LOCK_GOOD_CMP = 3;
    // section indices match the select bit value
    localparam int SEC_RX = 0;
    localparam int SEC_TX = 1;
    // register port
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_ENABLE = 4'h4;
    localparam logic [3:0] ADDR_CLEAR = 4'h8;
    localparam logic [3:0] ADDR_STATE = 4'hC;
    localparam int EV_W = 6;
    localparam int EV_RX_UNLOCK = 0;
    localparam int EV_TX_UNLOCK = 1;
    localparam int EV_RX_LOCK = 2;
    localparam int EV_TX_LOCK = 3;
    localparam int EV_RX_LOAD = 4;
    localparam int EV_TX_LOAD = 5;
    // reset values
    localparam logic [10:0] RST_N = 11'h010;
    localparam logic [6:0] RST_A = 7'h00;
    localparam logic RST_POL = 1'b1;
    localparam logic RST_REF = 1'b0;
    localparam logic RST_MON = 1'b0;
    localparam logic [5:0] RST_ENABLE = 6'h00;

    typedef struct packed {
        logic [10:0] n;
        logic [6:0] a;
        logic pol;
    } dpss_sect_cfg_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } dpss_bus_req_t;
endpackage

// ### logic/dpss_swallow_div.sv
// pulse-swallow divider of one section: dual modulus prescaler, swallow counter
// and programmable counter; assumes vco_edge is a one-cycle pulse per vco rise
`timescale 1ns/100ps
module dpss_swallow_div #(
    parameter int N_W = 11,
    parameter int A_W = 7,
    parameter int PRE_MOD = 64
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic vco_edge,
    input wire logic [N_W-1:0] div_n,
    input wire logic [A_W-1:0] div_a,
    output logic div_pulse
);
    localparam int PW = $clog2(PRE_MOD + 1);
    localparam logic [PW-1:0] LAST_SHORT = PW'(PRE_MOD - 1);
    localparam logic [PW-1:0] LAST_LONG = PW'(PRE_MOD);

    generate
        if (PRE_MOD < 2 || N_W < 5 || A_W < 1) begin : g_bad
            $error("dpss_swallow_div: unsupported parameter values");
        end
    endgenerate

    logic [PW-1:0] pres_ff;
    logic [A_W-1:0] swal_ff;
    logic [N_W-1:0] prog_ff;
    logic swallowing;
    logic pres_wrap;
    logic prog_done;

    // modulus 65 while swallow count below A, then 64
    assign swallowing = swal_ff < div_a;
    assign pres_wrap = vco_edge && (pres_ff == (swallowing ? LAST_LONG : LAST_SHORT));
    // compare one wider so prog_ff plus one cannot wrap at all ones
    assign prog_done = ({1'b0, prog_ff} + {{N_W{1'b0}}, 1'b1}) >= {1'b0, div_n};

    // prescaler stage
    always_ff @(posedge clk) begin
        if (rst) begin
            pres_ff <= '0;
        end else if (pres_wrap) begin
            pres_ff <= '0;
        end else if (vco_edge) begin
            pres_ff <= pres_ff + 1'b1;
        end
    end

    // swallow and programmable counters; total is 64*N + A edges while A < N
    always_ff @(posedge clk) begin
        if (rst) begin
            swal_ff <= '0;
            prog_ff <= '0;
            div_pulse <= 1'b0;
        end else begin
            div_pulse <= 1'b0;
            if (pres_wrap) begin
                if (prog_done) begin
                    swal_ff <= '0;
                    prog_ff <= '0;
                    div_pulse <= 1'b1;
                end else begin
                    prog_ff <= prog_ff + 1'b1;
                    if (swallowing) begin
                        swal_ff <= swal_ff + 1'b1;
                    end
                end
            end
        end
    end
endmodule

// ### logic/dpss_top.sv
// dual pll synthesiser digital core: serial loader, section latches, reference
// counter, two dividers, phase detectors, lock flags, switches and interrupts
// assumes every pin input, vco and crystal included, is sampled on clk and that
// clk runs far faster than any of them
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/100ps
module dpss_top #(
    parameter int LOCK_CYC = dpss_pkg::LOCK_WINDOW_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic latch_strobe,
    input wire logic xtal_in,
    input wire logic tx_vco_in,
    input wire logic rx_vco_in,
    input wire dpss_pkg::dpss_bus_req_t bus_req,
    output logic [7:0] rdata,
    output logic irq,
    output logic tx_pump_out,
    output logic tx_pump_oe,
    output logic rx_pump_out,
    output logic rx_pump_oe,
    output logic tx_switch_out,
    output logic tx_switch_oe,
    output logic rx_switch_out,
    output logic rx_switch_oe,
    output logic tx_lock_flag,
    output logic rx_lock_flag,
    output logic div_monitor,
    output logic ref_monitor
);
    localparam int EW = $clog2(LOCK_CYC + 1);
    localparam logic [EW-1:0] WIN = EW'(LOCK_CYC);
    localparam logic [1:0] GOOD_LAST = 2'(dpss_pkg::LOCK_GOOD_CMP - 1);
    localparam logic [9:0] REF_LAST_HI = 10'(dpss_pkg::REF_DIV_HI - 1);
    localparam logic [9:0] REF_LAST_LO = 10'(dpss_pkg::REF_DIV_LO - 1);

    generate
        if (LOCK_CYC < 1 || dpss_pkg::LOCK_GOOD_CMP > 4) begin : g_bad
            $error("dpss_top: unsupported lock window settings");
        end
    endgenerate

    // sampled pins for edge detection
    logic sclk_q_ff;
    logic xtal_q_ff;
    logic strobe_q_ff;
    logic [1:0] vco_q_ff;
    logic [1:0] vco_now;
    logic [1:0] vco_edge;
    logic sclk_rise;
    logic xtal_rise;

    assign vco_now = {tx_vco_in, rx_vco_in};
    assign sclk_rise = serial_clk & ~sclk_q_ff;
    assign xtal_rise = xtal_in & ~xtal_q_ff;
    assign vco_edge = vco_now & ~vco_q_ff;

    // previous pin levels
    always_ff @(posedge clk) begin
        if (rst) begin
            sclk_q_ff <= 1'b0;
            xtal_q_ff <= 1'b0;
            strobe_q_ff <= 1'b0;
            vco_q_ff <= 2'h0;
        end else begin
            sclk_q_ff <= serial_clk;
            xtal_q_ff <= xtal_in;
            strobe_q_ff <= latch_strobe;
            vco_q_ff <= vco_now;
        end
    end

    // serial shift register, newest bit enters at bit 0
    logic [dpss_pkg::SR_BITS-1:0] shift_ff;
    logic section_select_bit;

    always_ff @(posedge clk) begin
        if (rst) begin
            shift_ff <= '0;
        end else if (sclk_rise) begin
            shift_ff <= {shift_ff[dpss_pkg::SR_BITS-2:0], serial_data};
        end
    end

    assign section_select_bit = shift_ff[dpss_pkg::POS_SEL];

    // field extraction, plain binary with lowest bit least significant
    dpss_pkg::dpss_sect_cfg_t word_cfg;
    assign word_cfg.n = shift_ff[dpss_pkg::POS_N_LSB +: dpss_pkg::N_W];
    assign word_cfg.a = shift_ff[dpss_pkg::POS_A_LSB +: dpss_pkg::A_W];
    assign word_cfg.pol = shift_ff[dpss_pkg::POS_POL];

    // section latches; level transparent while strobe high, filler bit ignored
    dpss_pkg::dpss_sect_cfg_t cfg_ff [2];
    logic ref_ratio_ff;
    logic monitor_select_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_ff[0] <= '{n: dpss_pkg::RST_N, a: dpss_pkg::RST_A, pol: dpss_pkg::RST_POL};
            cfg_ff[1] <= '{n: dpss_pkg::RST_N, a: dpss_pkg::RST_A, pol: dpss_pkg::RST_POL};
            ref_ratio_ff <= dpss_pkg::RST_REF;
            monitor_select_ff <= dpss_pkg::RST_MON;
        end else if (latch_strobe) begin
            // the other section keeps its contents untouched
            if (section_select_bit) begin
                cfg_ff[dpss_pkg::SEC_TX] <= word_cfg;
            end else begin
                cfg_ff[dpss_pkg::SEC_RX] <= word_cfg;
            end
            ref_ratio_ff <= shift_ff[dpss_pkg::POS_REF];
            monitor_select_ff <= shift_ff[dpss_pkg::POS_MON];
        end
    end

    // shared reference counter on crystal edges
    logic [9:0] ref_cnt_ff;
    logic ref_pulse_ff;
    logic ref_wrap;

    assign ref_wrap = xtal_rise &&
        (ref_cnt_ff == (ref_ratio_ff ? REF_LAST_HI : REF_LAST_LO));

    always_ff @(posedge clk) begin
        if (rst) begin
            ref_cnt_ff <= 10'h000;
            ref_pulse_ff <= 1'b0;
        end else begin
            ref_pulse_ff <= ref_wrap;
            if (ref_wrap) begin
                ref_cnt_ff <= 10'h000;
            end else if (xtal_rise) begin
                ref_cnt_ff <= ref_cnt_ff + 10'h001;
            end
        end
    end

    // per-section divider, phase detector, lock flag and switch
    logic [1:0] div_pulse;
    logic [1:0] lock_vec;
    logic [1:0] pump_vec;
    logic [1:0] pump_oe_vec;
    logic [1:0] sw_vec;
    logic [1:0] sw_oe_vec;

    generate
        for (genvar s = 0; s < 2; s++) begin : g_sec
            logic up_ff;
            logic dn_ff;
            logic spike_ff;
            logic pump_ff;
            logic pump_oe_ff;
            logic sw_ff;
            logic sw_oe_ff;
            logic lock_ff;
            logic [EW-1:0] err_ff;
            logic [1:0] good_ff;
            logic nxt_pump;
            logic nxt_pump_oe;
            logic up_lvl;
            logic cmp_end;
            logic sw_on;

            dpss_swallow_div #(
                .N_W(dpss_pkg::N_W),
                .A_W(dpss_pkg::A_W),
                .PRE_MOD(dpss_pkg::PRESCALE_MOD)
            ) u_div (
                .clk(clk),
                .rst(rst),
                .vco_edge(vco_edge[s]),
                .div_n(cfg_ff[s].n),
                .div_a(cfg_ff[s].a),
                .div_pulse(div_pulse[s])
            );

            // both flags high means one comparison has ended
            assign cmp_end = up_ff & dn_ff;
            assign up_lvl = cfg_ff[s].pol;

            // frequency-phase detector: two-flag design spans -2pi..+2pi
            always_ff @(posedge clk) begin
                if (rst || cmp_end) begin
                    up_ff <= 1'b0;
                    dn_ff <= 1'b0;
                end else begin
                    if (ref_pulse_ff) begin
                        up_ff <= 1'b1;
                    end
                    if (div_pulse[s]) begin
                        dn_ff <= 1'b1;
                    end
                end
            end

            // pump drive; the coincidence cycle plus a follow-up cycle form a
            // balanced spike pair so a locked loop still sees pulses
            always_comb begin
                nxt_pump = 1'b0;
                nxt_pump_oe = 1'b0;
                if (cmp_end) begin
                    nxt_pump = up_lvl;
                    nxt_pump_oe = 1'b1;
                end else if (spike_ff) begin
                    nxt_pump = ~up_lvl;
                    nxt_pump_oe = 1'b1;
                end else if (up_ff) begin
                    nxt_pump = up_lvl;
                    nxt_pump_oe = 1'b1;
                end else if (dn_ff) begin
                    nxt_pump = ~up_lvl;
                    nxt_pump_oe = 1'b1;
                end
            end

            assign sw_on = latch_strobe && (section_select_bit == 1'(s));

            // pump and switch outputs share one next value
            always_ff @(posedge clk) begin
                if (rst) begin
                    spike_ff <= 1'b0;
                    pump_ff <= 1'b0;
                    pump_oe_ff <= 1'b0;
                    sw_ff <= 1'b0;
                    sw_oe_ff <= 1'b0;
                end else begin
                    spike_ff <= cmp_end;
                    pump_ff <= nxt_pump;
                    pump_oe_ff <= nxt_pump_oe;
                    sw_ff <= sw_on & nxt_pump;
                    sw_oe_ff <= sw_on & nxt_pump_oe;
                end
            end

            // lock detection on phase error width in clk cycles
            always_ff @(posedge clk) begin
                if (rst) begin
                    err_ff <= '0;
                    good_ff <= 2'h0;
                    lock_ff <= 1'b0;
                end else if (cmp_end) begin
                    err_ff <= '0;
                    if (err_ff < WIN) begin
                        if (good_ff >= GOOD_LAST) begin
                            lock_ff <= 1'b1;
                        end else begin
                            good_ff <= good_ff + 2'h1;
                        end
                    end
                end else if (up_ff ^ dn_ff) begin
                    if (err_ff < WIN) begin
                        err_ff <= err_ff + 1'b1;
                    end
                    // unlock on the very cycle the window is reached
                    if (err_ff + 1'b1 >= WIN) begin
                        lock_ff <= 1'b0;
                        good_ff <= 2'h0;
                    end
                end
            end

            assign lock_vec[s] = lock_ff;
            assign pump_vec[s] = pump_ff;
            assign pump_oe_vec[s] = pump_oe_ff;
            assign sw_vec[s] = sw_ff;
            assign sw_oe_vec[s] = sw_oe_ff;
        end
    endgenerate

    assign tx_pump_out = pump_vec[dpss_pkg::SEC_TX];
    assign tx_pump_oe = pump_oe_vec[dpss_pkg::SEC_TX];
    assign rx_pump_out = pump_vec[dpss_pkg::SEC_RX];
    assign rx_pump_oe = pump_oe_vec[dpss_pkg::SEC_RX];
    assign tx_switch_out = sw_vec[dpss_pkg::SEC_TX];
    assign tx_switch_oe = sw_oe_vec[dpss_pkg::SEC_TX];
    assign rx_switch_out = sw_vec[dpss_pkg::SEC_RX];
    assign rx_switch_oe = sw_oe_vec[dpss_pkg::SEC_RX];
    assign tx_lock_flag = lock_vec[dpss_pkg::SEC_TX];
    assign rx_lock_flag = lock_vec[dpss_pkg::SEC_RX];

    // monitor outputs, registered pulses one clk wide
    logic div_mon_ff;
    logic ref_mon_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            div_mon_ff <= 1'b0;
            ref_mon_ff <= 1'b0;
        end else begin
            div_mon_ff <= monitor_select_ff ? div_pulse[dpss_pkg::SEC_TX]
                                            : div_pulse[dpss_pkg::SEC_RX];
            ref_mon_ff <= ref_pulse_ff;
        end
    end

    assign div_monitor = div_mon_ff;
    assign ref_monitor = ref_mon_ff;

    // interrupt events from lock changes and strobe rise
    logic [1:0] lock_prev_ff;
    logic [dpss_pkg::EV_W-1:0] ev_set;
    logic strobe_rise;

    assign strobe_rise = latch_strobe & ~strobe_q_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            lock_prev_ff <= 2'h0;
        end else begin
            lock_prev_ff <= lock_vec;
        end
    end

    always_comb begin
        ev_set = '0;
        ev_set[dpss_pkg::EV_RX_UNLOCK] = lock_prev_ff[0] & ~lock_vec[0];
        ev_set[dpss_pkg::EV_TX_UNLOCK] = lock_prev_ff[1] & ~lock_vec[1];
        ev_set[dpss_pkg::EV_RX_LOCK] = ~lock_prev_ff[0] & lock_vec[0];
        ev_set[dpss_pkg::EV_TX_LOCK] = ~lock_prev_ff[1] & lock_vec[1];
        ev_set[dpss_pkg::EV_RX_LOAD] = strobe_rise & ~section_select_bit;
        ev_set[dpss_pkg::EV_TX_LOAD] = strobe_rise & section_select_bit;
    end

    // status, enable and clear; a set in the clearing cycle survives
    logic [dpss_pkg::EV_W-1:0] status_ff;
    logic [dpss_pkg::EV_W-1:0] enable_ff;
    logic [dpss_pkg::EV_W-1:0] clr;
    logic [dpss_pkg::EV_W-1:0] nxt_status;
    logic irq_ff;

    assign clr = (bus_req.wr && bus_req.addr == dpss_pkg::ADDR_CLEAR)
               ? bus_req.wdata[dpss_pkg::EV_W-1:0] : '0;
    assign nxt_status = (status_ff & ~clr) | ev_set;

    always_ff @(posedge clk) begin
        if (rst) begin
            status_ff <= '0;
            enable_ff <= dpss_pkg::RST_ENABLE;
            irq_ff <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            if (bus_req.wr && bus_req.addr == dpss_pkg::ADDR_ENABLE) begin
                enable_ff <= bus_req.wdata[dpss_pkg::EV_W-1:0];
            end
            irq_ff <= |(nxt_status & enable_ff);
        end
    end

    assign irq = irq_ff;

    // read data one cycle after the strobe, zero elsewhere and for holes
    logic [7:0] rdata_ff;
    logic [7:0] state_word;

    assign state_word = {3'h0, monitor_select_ff, ref_ratio_ff, section_select_bit,
                         lock_vec[1], lock_vec[0]};

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_ff <= 8'h00;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                dpss_pkg::ADDR_STATUS: rdata_ff <= {2'h0, status_ff};
                dpss_pkg::ADDR_ENABLE: rdata_ff <= {2'h0, enable_ff};
                dpss_pkg::ADDR_STATE: rdata_ff <= state_word;
                default: rdata_ff <= 8'h00;
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign rdata = rdata_ff;
endmodule

// ### sim/dpss_host_model.sv
// host controller model: shifts one 23-bit word and holds the latch strobe
// assumes the bench calls send_word once reset has been released
`timescale 1ns/100ps
module dpss_host_model (
    input wire logic clk,
    output logic serial_clk,
    output logic serial_data,
    output logic latch_strobe
);
    // serial clock stands low between frames
    initial begin
        serial_clk = 1'b0;
        serial_data = 1'b0;
        latch_strobe = 1'b0;
    end

    // first bit is the top divider bit, so the section select goes last
    task automatic send_word(input logic [10:0] n, input logic [6:0] a, input logic pol,
        input logic mon, input logic rf, input logic sel, input int hold);
        logic [22:0] w;
        w = {n, a, pol, 1'b0, mon, rf, sel};
        for (int i = 22; i >= 0; i--) begin
            @(posedge clk);
            serial_clk <= 1'b0;
            serial_data <= w[i];
            @(posedge clk);
            serial_clk <= 1'b1;
        end
        @(posedge clk);
        serial_clk <= 1'b0;
        latch_strobe <= 1'b1;
        repeat (hold) @(posedge clk);
        latch_strobe <= 1'b0;
    endtask
endmodule

// ### sim/dpss_top_assertions.sv
// concurrent checks on the synthesiser core ports: switches, reference monitor, lock flag
// assumes one clock and a synchronous active-high reset; bound to dpss_top below
`timescale 1ns/100ps
module dpss_top_checker #(
    parameter int LOCK_CYC = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic latch_strobe,
    input wire logic tx_pump_out,
    input wire logic tx_pump_oe,
    input wire logic tx_switch_out,
    input wire logic tx_switch_oe,
    input wire logic rx_switch_oe,
    input wire logic tx_lock_flag,
    input wire logic ref_monitor
);
    logic [15:0] err_run_ff;
    logic [1:0] cmp_seen_ff;

    // width of the current tx error pulse, saturating so it never wraps to zero
    always_ff @(posedge clk) begin
        if (rst || !tx_pump_oe) begin
            err_run_ff <= 16'h0000;
        end else if (err_run_ff != 16'hFFFF) begin
            err_run_ff <= err_run_ff + 16'h0001;
        end
    end

    // reference wraps seen while unlocked; stops at three
    always_ff @(posedge clk) begin
        if (rst || tx_lock_flag) begin
            cmp_seen_ff <= 2'h0;
        end else if (ref_monitor && cmp_seen_ff != 2'h3) begin
            cmp_seen_ff <= cmp_seen_ff + 2'h1;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_strobe_low;
        !latch_strobe [*2];
    endsequence

    // margin of four covers the registered detector and flag stages
    sequence s_long_error;
        tx_pump_oe && (err_run_ff > 16'(LOCK_CYC + 4));
    endsequence

    a_switch_off_idle: assert property (s_strobe_low |-> !tx_switch_oe && !rx_switch_oe)
        else $error("switch on with strobe low");
    a_switch_one_side: assert property (!(tx_switch_oe && rx_switch_oe))
        else $error("both switches on");
    a_switch_copy_pump: assert property (tx_switch_oe |->
        tx_pump_oe && tx_switch_out == tx_pump_out)
        else $error("tx switch differs from pump");
    a_ref_pulse_short: assert property (ref_monitor |=> !ref_monitor [*8])
        else $error("reference monitor pulse too close");
    a_lock_after_cmp: assert property ($rose(tx_lock_flag) |-> cmp_seen_ff == 2'h3)
        else $error("lock before three comparisons");
    a_unlock_long_err: assert property (s_long_error |-> !tx_lock_flag)
        else $error("lock kept over a wide error");
    a_unlock_on_err: assert property ($fell(tx_lock_flag) |->
        $past(tx_pump_oe) || $past(tx_pump_oe, 2))
        else $error("unlock without an error pulse");
    a_locked_spike: assert property (tx_lock_flag && ref_monitor |->
        ($past(tx_pump_oe) || $past(tx_pump_oe, 2)) or (##[0:8] tx_pump_oe))
        else $error("no correction pulse while locked");
endmodule

bind dpss_top dpss_top_checker #(.LOCK_CYC(LOCK_CYC)) u_chk (.*);

// ### sim/tb_top.sv
// self-checking bench of the synthesiser core: lock, interrupts, loading, monitors
// assumes the host model drives the serial pins; crystal and vcos are made here
`timescale 1ns/100ps
module tb_top;
    localparam int LK = 16;
    logic clk, rst, xtal_in, tx_vco_in, rx_vco_in, serial_clk, serial_data, latch_strobe;
    dpss_pkg::dpss_bus_req_t bus_req;
    logic [7:0] rdata;
    logic irq, tx_pump_out, tx_pump_oe, rx_pump_out, rx_pump_oe, tx_switch_out;
    logic tx_switch_oe, rx_switch_out, rx_switch_oe, tx_lock_flag, rx_lock_flag;
    logic div_monitor, ref_monitor;
    logic [1:0] ph_ff;
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;
    int pol = 0;

    dpss_top #(.LOCK_CYC(LK)) u_dut (.*);
    dpss_host_model u_host (.*);

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // crystal and vcos share one divider so the reset settings lock; also the hang limit
    always @(posedge clk) begin
        ph_ff <= ph_ff + 2'h1;
        xtal_in <= ph_ff[1];
        tx_vco_in <= ph_ff[1];
        rx_vco_in <= ph_ff[1];
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // both bus tasks end at a falling edge so outputs are settled
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req <= '0;
        @(negedge clk);
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req <= '0;
        @(negedge clk);
        d = rdata;
    endtask

    // second interval between monitor pulses; the divider gap tallies the loaded pump
    task automatic gap(input bit sel, input bit tx, output int n);
        for (int i = 0; i < 2; i++) begin
            n = 0;
            do begin
                @(negedge clk);
                n++;
                if (sel && (tx ? tx_pump_oe : rx_pump_oe) === 1'b1) begin
                    pol += ((tx ? tx_pump_out : rx_pump_out) === 1'b1) ? 1 : -1;
                end
            end while ((sel ? div_monitor : ref_monitor) !== 1'b1 && n < 9000);
        end
    endtask

    task automatic t_lock_irq();
        logic [7:0] d;
        int i;
        check("reset flags", 16'h0, {tx_lock_flag, rx_lock_flag, tx_pump_oe, irq});
        for (i = 0; i < 30000 && !(tx_lock_flag === 1'b1 && rx_lock_flag === 1'b1); i++) begin
            @(negedge clk);
        end
        check("irq masked", 16'h0, irq);
        wr(dpss_pkg::ADDR_STATUS, 8'hFF);
        rd(dpss_pkg::ADDR_STATUS, d);
        check("lock events", 16'h0C, d);
        wr(dpss_pkg::ADDR_ENABLE, 8'h08);
        repeat (2) @(negedge clk);
        check("irq raised", 16'h1, irq);
        wr(dpss_pkg::ADDR_CLEAR, 8'h0C);
        repeat (2) @(negedge clk);
        check("irq cleared", 16'h0, irq);
        rd(4'h2, d);
        check("unmapped read", 16'h0, d);
        $display("test lock and interrupt done");
    endtask

    // one section load held long enough to see the switch follow the pump
    task automatic t_load(input bit tx, input int n, input int a, input logic rf, output int nd,
        output int nr);
        int hi, lo;
        logic [7:0] d;
        hi = 0;
        lo = 0;
        fork
            u_host.send_word(11'(n), 7'(a), tx, tx, rf, tx, 5000);
            begin
                wait (latch_strobe === 1'b1);
                while (latch_strobe === 1'b1) begin
                    @(negedge clk);
                    hi += int'(tx_switch_oe === 1'b1);
                    lo += int'(rx_switch_oe === 1'b1);
                end
            end
        join
        check("chosen switch", 16'h1, 16'(tx ? hi > 0 : lo > 0));
        check("other switch", 16'h0, 16'(tx ? lo : hi));
        rd(dpss_pkg::ADDR_STATE, d);
        check("state fields", {13'h0, tx, rf, tx}, 16'(d[4:2]));
        pol = 0;
        gap(1'b1, tx, nd);
        gap(1'b0, tx, nr);
    endtask

    task automatic t_tx_rx();
        int nd, nr;
        logic [7:0] d;
        t_load(1'b1, 20, 3, 1'b0, nd, nr);
        check("tx divide", 16'((64 * 20 + 3) * 4), 16'(nd));
        check("ref 1024", 16'(1024 * 4), 16'(nr));
        check("tx polarity", 16'h1, 16'(pol > 0));
        check("tx unlock", 16'h0, tx_lock_flag);
        check("rx kept", 16'h1, rx_lock_flag);
        $display("test transmit load done");
        t_load(1'b0, 16, 0, 1'b1, nd, nr);
        check("rx divide", 16'(16 * 64 * 4), 16'(nd));
        check("ref 512", 16'(512 * 4), 16'(nr));
        check("rx polarity", 16'h1, 16'(pol < 0));
        rd(dpss_pkg::ADDR_STATUS, d);
        check("load events", 16'h33, 16'(d & 8'h33));
        $display("test reception load done");
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        bus_req = '0;
        ph_ff = 2'h0;
        xtal_in = 1'b0;
        tx_vco_in = 1'b0;
        rx_vco_in = 1'b0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        t_lock_irq();
        t_tx_rx();
        give_verdict();
    end
endmodule
